// [src/cascade_timer_pkg.sv]
// Constants for the cascaded 16-bit event timer
`default_nettype none
package cascade_timer_pkg;
  localparam int          AW            = 8;
  // Register byte offsets
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_CLKSEL    = 8'h04;
  localparam logic [7:0]  OFS_OUTCTL    = 8'h08;
  localparam logic [7:0]  OFS_LOWCMP    = 8'h0C;
  localparam logic [7:0]  OFS_HIGHCMP   = 8'h10;
  localparam logic [7:0]  OFS_COUNT     = 8'h14;
  localparam logic [7:0]  OFS_STATUS    = 8'h18;
  localparam logic [7:0]  OFS_MASK      = 8'h1C;
  // Mode register fields
  localparam int          MODE_EN_BIT   = 0;
  localparam int          MODE_CASC_BIT = 2;
  // Output control fields
  localparam int          OUT_LVR1_BIT  = 2;
  localparam int          OUT_LVS1_BIT  = 3;
  localparam int          OUT_EN2_BIT   = 4;
  localparam int          OUT_EN1_BIT   = 0;
  localparam int          OUT_HIGH_OUT_LEVEL_RESET_BIT  = 6;
  localparam int          OUT_HIGH_OUT_LEVEL_SET_BIT  = 7;
  // Status / mask fields
  localparam int          ST_LOW_BIT    = 0;
  localparam int          ST_CASC_BIT   = 1;
  // Clock select codes
  localparam logic [3:0]  CS_EXT_FALL   = 4'h0;
  localparam logic [3:0]  CS_EXT_RISE   = 4'h1;
  localparam logic [3:0]  CS_INT_FIRST  = 4'h6;
  localparam logic [3:0]  CS_INT_LAST   = 4'hF;
  // Reset values; prescaler width
  localparam logic [7:0]  RST_MODE      = 8'h00;
  localparam logic [3:0]  RST_CLKSEL    = 4'h0;
  localparam logic [7:0]  RST_OUTCTL    = 8'h00;
  localparam logic [7:0]  RST_CMP       = 8'h00;
  localparam logic [1:0]  RST_MASK      = 2'h3;
  localparam int          PRE_W         = 12;
endpackage
`default_nettype wire

// [src/count_tick_sel.sv]
// Count-clock source: prescaler taps and external edge detection
`default_nettype none
module count_tick_sel #(
  parameter int PRE_W = cascade_timer_pkg::PRE_W
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [3:0] clkSel,
  input  wire logic       eventInput,
  output logic            tick
);
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic             evtPrev_ff;
  logic             nxt_evtPrev;
  logic [PRE_W-1:0] tapHit;

  // Each internal code picks a power-of-two divide of the system clock
  genvar g;
  generate
    for (g = 0; g < PRE_W; g++) begin : gTap
      assign tapHit[g] = &pre_ff[g:0];
    end
  endgenerate

  always_comb begin
    // Prescaler restarts with the timer; pin edges are not aligned to start, so the first count may come early
    nxt_pre     = run ? pre_ff + 1'b1 : '0;
    nxt_evtPrev = eventInput;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff     <= '0;
      evtPrev_ff <= 1'b0;
    end else if (clkEn) begin
      pre_ff     <= nxt_pre;
      evtPrev_ff <= nxt_evtPrev;
    end
  end

  always_comb begin
    tick = 1'b0;
    case (clkSel)
      cascade_timer_pkg::CS_EXT_FALL: tick = evtPrev_ff & ~eventInput;
      cascade_timer_pkg::CS_EXT_RISE: tick = ~evtPrev_ff & eventInput;
      default: begin
        if (clkSel >= cascade_timer_pkg::CS_INT_FIRST)
          tick = tapHit[clkSel - cascade_timer_pkg::CS_INT_FIRST];
      end
    endcase
    tick = tick & run & clkEn;
  end
endmodule
`default_nettype wire

// [src/cascade_event_timer.sv]
// Cascaded 16-bit timer / event counter with APB register slave
`default_nettype none
module cascade_event_timer #(
  parameter int PRE_W = cascade_timer_pkg::PRE_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          clkEn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cascade_timer_pkg::AW-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          eventInput,
  output logic                               lowChannelOut,
  output logic                               highChannelOut,
  output logic                               irq
);
  logic [7:0] mode_ff,    nxt_mode;
  logic [3:0] clkSel_ff,  nxt_clkSel;
  logic [7:0] outCtl_ff,  nxt_outCtl;
  logic [7:0] lowCmp_ff,  nxt_lowCmp;
  logic [7:0] highCmp_ff, nxt_highCmp;
  logic [1:0] mask_ff,    nxt_mask;
  logic [1:0] status_ff,  nxt_status;
  logic [7:0] lowCnt_ff,  nxt_lowCnt;
  logic [7:0] highCnt_ff, nxt_highCnt;
  logic       lowOut_ff,  nxt_lowOut;
  logic       highOut_ff, nxt_highOut;
  logic [31:0] rdata_ff,  nxt_rdata;

  logic       run;
  logic       cascade;
  logic       lowTick;
  logic       highTick;
  logic       lowMatch;
  logic       highMatch;
  logic       cascMatch;
  logic       access;
  logic       wrEn;
  logic       rdEn;
  logic       mapped;

  assign run     = mode_ff[cascade_timer_pkg::MODE_EN_BIT];
  assign cascade = mode_ff[cascade_timer_pkg::MODE_CASC_BIT];

  count_tick_sel #(
    .PRE_W      (PRE_W)
  ) uTick (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .run        (run),
    .clkSel     (clkSel_ff),
    .eventInput (eventInput),
    .tick       (lowTick)
  );

  // APB: zero wait states, every access answered in its access cycle
  assign access  = psel & penable & clkEn;
  assign wrEn    = access & pwrite;
  assign rdEn    = access & ~pwrite;
  assign pready  = 1'b1;

  always_comb begin
    case (paddr)
      cascade_timer_pkg::OFS_MODE,   cascade_timer_pkg::OFS_CLKSEL,
      cascade_timer_pkg::OFS_OUTCTL, cascade_timer_pkg::OFS_LOWCMP,
      cascade_timer_pkg::OFS_HIGHCMP, cascade_timer_pkg::OFS_COUNT,
      cascade_timer_pkg::OFS_STATUS, cascade_timer_pkg::OFS_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // Match logic; compare of zero matches from the start, so the first tick is already an event
  assign lowMatch  = (lowCnt_ff == lowCmp_ff);
  assign highMatch = (highCnt_ff == highCmp_ff);
  assign cascMatch = cascade & run & lowTick & lowMatch & highMatch;
  // In independent mode the high counter has no source in this block
  assign highTick  = cascade & lowTick & (lowCnt_ff == 8'hFF);

  always_comb begin
    nxt_mode    = mode_ff;
    nxt_clkSel  = clkSel_ff;
    nxt_outCtl  = outCtl_ff;
    nxt_lowCmp  = lowCmp_ff;
    nxt_highCmp = highCmp_ff;
    nxt_mask    = mask_ff;
    if (wrEn) begin
      case (paddr)
        cascade_timer_pkg::OFS_MODE:    nxt_mode    = pwdata[7:0];
        cascade_timer_pkg::OFS_CLKSEL:  nxt_clkSel  = pwdata[3:0];
        cascade_timer_pkg::OFS_OUTCTL:  nxt_outCtl  = {2'b00, pwdata[5:4], 2'b00, pwdata[1:0]};
        cascade_timer_pkg::OFS_LOWCMP:  nxt_lowCmp  = pwdata[7:0];
        cascade_timer_pkg::OFS_HIGHCMP: nxt_highCmp = pwdata[7:0];
        cascade_timer_pkg::OFS_MASK:    nxt_mask    = pwdata[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_lowCnt  = lowCnt_ff;
    nxt_highCnt = highCnt_ff;
    if (!run) begin
      nxt_lowCnt  = '0;
      nxt_highCnt = '0;
    end else if (cascMatch) begin
      nxt_lowCnt  = '0;
      nxt_highCnt = '0;
    end else if (lowTick) begin
      // A lowered compare is passed by; the counter wraps and meets it later
      if (!cascade && lowMatch) nxt_lowCnt = '0;
      else nxt_lowCnt = lowCnt_ff + 8'h01;
      if (highTick) nxt_highCnt = highCnt_ff + 8'h01;
    end
  end

  always_comb begin
    logic lowEvt;
    lowEvt      = run & lowTick & lowMatch;
    nxt_lowOut  = lowOut_ff;
    nxt_highOut = highOut_ff;
    nxt_status  = status_ff;
    if (lowEvt && outCtl_ff[cascade_timer_pkg::OUT_EN1_BIT])
      nxt_lowOut = ~lowOut_ff;
    if (cascMatch && outCtl_ff[cascade_timer_pkg::OUT_EN2_BIT])
      nxt_highOut = ~highOut_ff;
    // A deliberate level write from software beats a toggle in the same cycle
    if (wrEn && paddr == cascade_timer_pkg::OFS_OUTCTL) begin
      if (pwdata[cascade_timer_pkg::OUT_LVR1_BIT]) nxt_lowOut = 1'b0;
      if (pwdata[cascade_timer_pkg::OUT_LVS1_BIT]) nxt_lowOut = 1'b1;
      if (pwdata[cascade_timer_pkg::OUT_HIGH_OUT_LEVEL_RESET_BIT]) nxt_highOut = 1'b0;
      if (pwdata[cascade_timer_pkg::OUT_HIGH_OUT_LEVEL_SET_BIT]) nxt_highOut = 1'b1;
    end
    // Read clears only the bits it returned: an event after the setup capture is not lost
    if (rdEn && paddr == cascade_timer_pkg::OFS_STATUS) nxt_status = status_ff & ~rdata_ff[1:0];
    if (lowEvt)    nxt_status[cascade_timer_pkg::ST_LOW_BIT]  = 1'b1;
    if (cascMatch) nxt_status[cascade_timer_pkg::ST_CASC_BIT] = 1'b1;
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        cascade_timer_pkg::OFS_MODE:    nxt_rdata = {24'h000000, mode_ff};
        cascade_timer_pkg::OFS_CLKSEL:  nxt_rdata = {28'h0000000, clkSel_ff};
        cascade_timer_pkg::OFS_OUTCTL:  nxt_rdata = {24'h000000, outCtl_ff};
        cascade_timer_pkg::OFS_LOWCMP:  nxt_rdata = {24'h000000, lowCmp_ff};
        cascade_timer_pkg::OFS_HIGHCMP: nxt_rdata = {24'h000000, highCmp_ff};
        cascade_timer_pkg::OFS_COUNT:   nxt_rdata = {16'h0000, highCnt_ff, lowCnt_ff};
        cascade_timer_pkg::OFS_STATUS:  nxt_rdata = {30'h0, status_ff};
        cascade_timer_pkg::OFS_MASK:    nxt_rdata = {30'h0, mask_ff};
        default:                        nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff    <= cascade_timer_pkg::RST_MODE;
      clkSel_ff  <= cascade_timer_pkg::RST_CLKSEL;
      outCtl_ff  <= cascade_timer_pkg::RST_OUTCTL;
      lowCmp_ff  <= cascade_timer_pkg::RST_CMP;
      highCmp_ff <= cascade_timer_pkg::RST_CMP;
      mask_ff    <= cascade_timer_pkg::RST_MASK;
      status_ff  <= '0;
      lowCnt_ff  <= '0;
      highCnt_ff <= '0;
      lowOut_ff  <= 1'b0;
      highOut_ff <= 1'b0;
      rdata_ff   <= '0;
    end else if (clkEn) begin
      mode_ff    <= nxt_mode;
      clkSel_ff  <= nxt_clkSel;
      outCtl_ff  <= nxt_outCtl;
      lowCmp_ff  <= nxt_lowCmp;
      highCmp_ff <= nxt_highCmp;
      mask_ff    <= nxt_mask;
      status_ff  <= nxt_status;
      lowCnt_ff  <= nxt_lowCnt;
      highCnt_ff <= nxt_highCnt;
      lowOut_ff  <= nxt_lowOut;
      highOut_ff <= nxt_highOut;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign prdata         = rdata_ff;
  assign lowChannelOut  = lowOut_ff;
  assign highChannelOut = highOut_ff;
  // Mask bit 1 blocks a status bit; both mask bits reset to 1, so irq stays quiet until unmasked
  assign irq            = |(status_ff & ~mask_ff);
endmodule
`default_nettype wire

// [testbench/cascade_event_timer_asserts.sv]
// Port-level checker for the cascaded event timer
`default_nettype none
module cascade_event_timer_asserts (
  input wire logic                              sys_clk,
  input wire logic                              rst_b,
  input wire logic                              clkEn,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [cascade_timer_pkg::AW-1:0] paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic [31:0]                      prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire logic                              eventInput,
  input wire logic                              lowChannelOut,
  input wire logic                              highChannelOut,
  input wire logic                              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable && clkEn;
  wire outWr = acc && pwrite && paddr == cascade_timer_pkg::OFS_OUTCTL;
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_count_upper: assert property (acc && !pwrite && paddr == cascade_timer_pkg::OFS_COUNT |-> prdata[31:16] == 16'h0)
    else $error("count upper half not zero");
  chk_outctl_read: assert property (acc && !pwrite && paddr == cascade_timer_pkg::OFS_OUTCTL |-> prdata[7:6] == 2'h0)
    else $error("level bits read back");
  chk_level_set: assert property (outWr && pwdata[7:6] == 2'h2 |=> highChannelOut)
    else $error("high output not set");
  chk_level_clear: assert property (outWr && pwdata[7:6] == 2'h1 |=> !highChannelOut)
    else $error("high output not cleared");
  chk_mask_quiet: assert property (acc && pwrite && paddr == cascade_timer_pkg::OFS_MASK && pwdata[1:0] == 2'h3 |=> !irq)
    else $error("irq with all masked");
  chk_irq_drop: assert property ($fell(irq) |-> $past(acc))
    else $error("irq fell without access");
  chk_freeze_hold: assert property (!clkEn |=> $stable({lowChannelOut, highChannelOut, irq, prdata}))
    else $error("state moved while frozen");
  cover property ($rose(irq));
  cover property ($rose(highChannelOut));
  cover property (pslverr);
endmodule
bind cascade_event_timer cascade_event_timer_asserts chk (.sys_clk, .rst_b, .clkEn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .eventInput, .lowChannelOut, .highChannelOut, .irq);
`default_nettype wire

// [testbench/event_source.sv]
// External pulse source on the event input pin
`default_nettype none
module event_source (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic on,
  output logic      eventInput
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;
  always_comb begin
    nxt_phase = on ? phase_ff + 2'h1 : phase_ff;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end
  // Two cycles high, two low: edges never closer than the pin sampler needs
  assign eventInput = phase_ff[1];
endmodule
`default_nettype wire

// [testbench/cascade_event_timer_bench.sv]
// Self-checking bench with an integer model of the timer
`default_nettype none
module cascade_event_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_b, clkEn, psel, penable, pwrite, srcOn, err, tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, expRd, seed;
  logic        pready, pslverr, eventInput, lowChannelOut, highChannelOut, irq;
  int          nMismatch, comparisons, cnt, cmp, st, mask, hiEn, run, sel, evP, hiOut, loOut, loEn, pre;
  cascade_event_timer dut (.sys_clk, .rst_b, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .eventInput, .lowChannelOut, .highChannelOut, .irq);
  event_source src (.sys_clk, .rst_b, .on(srcOn), .eventInput);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle, so the next call never reassigns psel in this time step
    @(posedge sys_clk);
  endtask
  task automatic rdm(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
    check(rd, expRd);
  endtask
  task automatic outs();
    @(negedge sys_clk);
    check({lowChannelOut, highChannelOut, irq}, {loOut[0], hiOut[0], (st & ~mask & 3) != 0});
    @(posedge sys_clk);
  endtask
  // Stop first, then load compare bytes, then start in cascade
  task automatic setup(input logic [31:0] s, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] m);
    apb(cascade_timer_pkg::OFS_MODE, 1'b1, 32'h0);
    apb(cascade_timer_pkg::OFS_OUTCTL, 1'b1, 32'h11);
    apb(cascade_timer_pkg::OFS_MASK, 1'b1, m);
    apb(cascade_timer_pkg::OFS_CLKSEL, 1'b1, s);
    apb(cascade_timer_pkg::OFS_LOWCMP, 1'b1, lo);
    apb(cascade_timer_pkg::OFS_HIGHCMP, 1'b1, hi);
    apb(cascade_timer_pkg::OFS_MODE, 1'b1, 32'h5);
  endtask
  // Reference model, updated in the same order as the design: clear, count, then register writes
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      {cnt, cmp, st, hiEn, run, sel, evP, hiOut, loOut, loEn, pre} = '0;
      mask = 3;
    end else if (clkEn) begin
      if (psel && !penable) expRd = paddr == cascade_timer_pkg::OFS_COUNT ? cnt : st;
      // A status read clears only what it reported; later events stay pending
      if (psel && penable && !pwrite && paddr == cascade_timer_pkg::OFS_STATUS) st &= ~int'(expRd);
      tick = run != 0 && sel < 2 && eventInput != evP[0] && eventInput == sel[0];
      if (run != 0 && sel >= 6) tick = (pre & ((2 << (sel - 6)) - 1)) == ((2 << (sel - 6)) - 1);
      pre = run != 0 ? (pre + 1) & 4095 : 0;
      if (tick) begin
        if ((cnt & 255) == (cmp & 255)) begin
          st |= 1;
          loOut ^= loEn;
        end
        if (cnt == cmp) begin
          cnt = 0;
          st |= 2;
          hiOut ^= hiEn;
        end else cnt = (cnt + 1) & 16'hFFFF;
      end
      if (psel && penable && pwrite) case (paddr)
        cascade_timer_pkg::OFS_MODE: run = pwdata[0];
        cascade_timer_pkg::OFS_CLKSEL: sel = pwdata[3:0];
        cascade_timer_pkg::OFS_OUTCTL: hiOut = pwdata[7] ? 1 : pwdata[6] ? 0 : hiOut;
        cascade_timer_pkg::OFS_LOWCMP: cmp = cmp & 16'hFF00 | pwdata[7:0];
        cascade_timer_pkg::OFS_HIGHCMP: cmp = cmp & 255 | pwdata[7:0] << 8;
        cascade_timer_pkg::OFS_MASK: mask = pwdata[1:0];
        default: ;
      endcase
      if (psel && penable && pwrite && paddr == cascade_timer_pkg::OFS_OUTCTL) begin
        hiEn = pwdata[4];
        loEn = pwdata[0];
        loOut = pwdata[3] ? 1 : pwdata[2] ? 0 : loOut;
      end
      if (run == 0) cnt = 0;
      evP = eventInput;
    end
  end
  task automatic reportAndStop();
    $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100us;
    nMismatch++;
    reportAndStop();
  end
  initial begin
    {rst_b, psel, penable, pwrite, srcOn, paddr, pwdata} = '0;
    clkEn = 1'b1;
    seed = 32'hBFE8;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      apb(8'(i * 4), 1'b0, 32'h0);
      check(rd, i == 7 ? 32'(cascade_timer_pkg::RST_MASK) : 32'h0);
    end
    apb(8'h20, 1'b0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(cascade_timer_pkg::OFS_OUTCTL, 1'b1, 32'h80);
    outs();
    apb(cascade_timer_pkg::OFS_OUTCTL, 1'b1, 32'h40);
    outs();
    setup(32'h1, 32'h2, 32'h1, 32'h1);
    srcOn <= 1'b1;
    repeat (1100 + (rnd() & 255)) begin
      @(posedge sys_clk);
      clkEn <= (rnd() & 7) != 0;
    end
    srcOn <= 1'b0;
    clkEn <= 1'b1;
    @(posedge sys_clk);
    outs();
    rdm(cascade_timer_pkg::OFS_COUNT);
    rdm(cascade_timer_pkg::OFS_STATUS);
    srcOn <= 1'b1;
    repeat (200) @(posedge sys_clk);
    apb(cascade_timer_pkg::OFS_HIGHCMP, 1'b1, 32'h0);
    repeat (600) @(posedge sys_clk);
    srcOn <= 1'b0;
    @(posedge sys_clk);
    rdm(cascade_timer_pkg::OFS_COUNT);
    rdm(cascade_timer_pkg::OFS_STATUS);
    setup(32'h6, 32'h3, 32'h0, 32'h1);
    repeat (100) @(posedge sys_clk);
    outs();
    rdm(cascade_timer_pkg::OFS_STATUS);
    setup(32'h0, 32'h0, 32'h0, 32'h0);
    srcOn <= 1'b1;
    repeat (40) @(posedge sys_clk);
    srcOn <= 1'b0;
    @(posedge sys_clk);
    outs();
    rdm(cascade_timer_pkg::OFS_STATUS);
    apb(cascade_timer_pkg::OFS_MODE, 1'b1, 32'h0);
    rdm(cascade_timer_pkg::OFS_COUNT);
    apb(cascade_timer_pkg::OFS_MASK, 1'b1, 32'h3);
    outs();
    reportAndStop();
  end
endmodule
`default_nettype wire
